// ==== core/mcx_pkg.sv ====
// constants, opcode encodings, register map and carriers for the core
// assumes: a single 100 MHz clock and an APB slave port of 32-bit words
package mcx_pkg;

   // ***************************************************************
   // widths and sizes
   // ***************************************************************
   localparam int PC_W = 11;
   localparam int DATA_W = 8;
   localparam int INSTR_W = 14;
   localparam int RADDR_W = 7;
   localparam int STACK_DEPTH = 8;
   localparam int PRESC_W = 8;
   localparam int WDOG_W = 8;
   localparam int APB_AW = 12;

   // ***************************************************************
   // instruction layout: [13:8] opcode, [7] destination, [6:0] register
   // ***************************************************************
   localparam logic [5:0] OP_NOP = 6'h00;
   localparam logic [5:0] OP_CLEAR_ACC = 6'h01;
   localparam logic [5:0] OP_CLEAR_REG = 6'h02;
   localparam logic [5:0] OP_COMPLEMENT = 6'h03;
   localparam logic [5:0] OP_COMPARE = 6'h04;
   localparam logic [5:0] OP_DEC_ADJUST = 6'h05;
   localparam logic [5:0] OP_DEC_SKIP = 6'h06;
   localparam logic [5:0] OP_DECREMENT = 6'h07;
   localparam logic [5:0] OP_IRQ_DISABLE = 6'h08;
   localparam logic [5:0] OP_IRQ_ENABLE = 6'h09;
   localparam logic [5:0] OP_INCREMENT = 6'h0a;
   localparam logic [5:0] OP_INC_SKIP = 6'h0b;
   localparam logic [5:0] OP_BRANCH_ACC = 6'h0c;
   localparam logic [5:0] OP_SOFT_INT = 6'h0d;
   localparam logic [5:0] OP_OR_IMM = 6'h0e;
   localparam logic [5:0] OP_OR_REG = 6'h0f;
   localparam logic [5:0] OP_FPAGE_STORE = 6'h10;
   localparam logic [5:0] OP_WDOG_CLEAR = 6'h11;
   localparam logic [5:0] OP_ADD_REG = 6'h12;
   // bit test: [13:10] prefix, [9:7] bit number, [6:0] register
   localparam logic [3:0] BIT_SKIP_PREFIX = 4'h5;
   localparam logic [13:0] NOP_WORD = 14'h0000;
   localparam logic [10:0] SOFT_INT_VECTOR = 11'h001;
   localparam logic [3:0] FPAGE_LO = 4'h5;
   localparam logic [3:0] FPAGE_HI = 4'hf;

   // ***************************************************************
   // register map (byte addresses)
   // ***************************************************************
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_ACC = 12'h008;
   localparam logic [11:0] REG_PC = 12'h00c;
   localparam logic [11:0] REG_TBL_HIGH = 12'h010;
   localparam logic [11:0] REG_WDOG = 12'h014;
   localparam logic [11:0] REG_STACK = 12'h018;
   localparam logic [11:0] REG_FPAGE_BASE = 12'h040;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [7:0] TBL_HIGH_RESET = 8'h00;

   // ***************************************************************
   // carriers
   // ***************************************************************
   typedef struct packed {
      logic dc;
      logic c;
      logic z;
   } mcx_flags_s;

   typedef struct packed {
      logic presc_to_wdog;
      logic wdog_en;
      logic run;
   } mcx_ctrl_s;

   typedef struct packed {
      logic we;
      logic [6:0] addr;
      logic [7:0] data;
   } mcx_wport_s;

endpackage

// ==== core/mcx_dreg_ram.sv ====
// data register space: 128 bytes, one write and one registered read port
// assumes: write and read share the clock; read-during-write gives new data
module mcx_dreg_ram #(
   parameter int AW = 7,
   parameter int DW = 8
) (
   input wire logic clk,                  // core clock
   input wire mcx_pkg::mcx_wport_s wport, // write strobe, address, data
   input wire logic [AW-1:0] rd_addr,     // read address
   output logic [DW-1:0] rd_data          // registered read data
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // write-first so a result stored this cycle is seen by the next op
   always_ff @(posedge clk) begin
      if (wport.we) begin
         mem[wport.addr] <= wport.data;
      end
      if (wport.we && wport.addr == rd_addr) begin
         rd_data <= wport.data;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

// ==== core/mcx_ret_stack.sv ====
// return-address stack with a wrapping push pointer
// assumes: only pushes come from this core; pops live elsewhere
module mcx_ret_stack #(
   parameter int DEPTH = 8,
   parameter int AW = 11
) (
   input wire logic clk,                         // core clock
   input wire logic rst_n,                       // async reset, active low
   input wire logic push,                        // one-cycle push strobe
   input wire logic [AW-1:0] push_addr,          // return address
   output logic [$clog2(DEPTH)-1:0] ptr,         // level count pointer
   output logic [AW-1:0] top                     // last pushed address
);

   logic [AW-1:0] level [0:DEPTH-1];

   // entries themselves need no reset; software never reads stale ones
   always_ff @(posedge clk) begin
      if (push) begin
         level[ptr] <= push_addr;
      end
   end

   // pointer steps once per push and wraps after the last level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr <= '0;
         top <= '0;
      end else if (push) begin
         ptr <= ptr + 1'b1;
         top <= push_addr;
      end
   end

endmodule

// ==== core/mcx_core.sv ====
// execution core for a subset of an 8-bit controller's instructions
// assumes: program memory answers PM_DATA combinationally from PM_ADDR,
// and software drives the registers through an APB slave port
//
// How it works
// [RQ1] bit test skips: register bit set turns fetched instruction to a nop
// [RQ2] clear accumulator loads zero and forces zero flag high
// [RQ3] clear register writes zero to the addressed byte, zero flag high
// [RQ4] complement inverts the register into the chosen destination, sets z
// [RQ5] destination bit zero selects accumulator, one writes register back
// [RQ6] watchdog clear zeroes counter, assigned prescaler, sets both flags
// [RQ7] compare forms register minus accumulator, touches only z and c
// [RQ8] decimal adjust corrects accumulator after an add, touches only c
// [RQ9] program puts the adjust right after the add, irq masked around it
// [RQ10] decrement-skip stores result, skips next when zero, flags untouched
// [RQ11] decrement stores register minus one and updates zero flag
// [RQ12] global disable clears the interrupt enable bit
// [RQ13] global enable sets the interrupt enable bit
// [RQ14] increment stores register plus one and updates zero flag
// [RQ15] increment-skip stores result, skips next when zero, flags untouched
// [RQ16] branch loads pc from table pointer low bits and accumulator
// [RQ17] soft interrupt pushes pc plus one, jumps to 0x001, three cycles
// [RQ18] or-immediate merges immediate into accumulator, updates zero flag
// [RQ19] or-register merges accumulator with register to destination, z
// [RQ20] f-page store copies accumulator to special byte 5..15, no flags
// [RQ21] carry is one on add carry-out or subtract without borrow
// [RQ22] timeout flag high after reset or clear, low on watchdog timeout
// [RQ23] zero flag follows whether the 8-bit result is zero
// [RQ24] return stack holds eight levels, pointer steps on each push
//
// Implementation choices: the placing of the registers and register access over APB.
module mcx_core #(
   parameter int STACK_DEPTH = mcx_pkg::STACK_DEPTH
) (
   input wire logic CORE_CLK,                        // core clock
   input wire logic RSTN,                            // async reset, low
   output logic [mcx_pkg::PC_W-1:0] PM_ADDR,         // fetch address
   input wire logic [mcx_pkg::INSTR_W-1:0] PM_DATA,  // fetched word
   output logic GLOBAL_IRQ_EN,                       // global irq enable
   output logic WDOG_TIMEOUT,                        // timeout pulse
   input wire logic PSEL,                            // apb select
   input wire logic PENABLE,                         // apb enable
   input wire logic PWRITE,                          // apb direction
   input wire logic [mcx_pkg::APB_AW-1:0] PADDR,     // apb byte address
   input wire logic [31:0] PWDATA,                   // apb write data
   output logic [31:0] PRDATA,                       // apb read data
   output logic PREADY,                              // apb ready
   output logic PSLVERR                              // apb error
);

   // ***************************************************************
   // state
   // ***************************************************************
   logic [mcx_pkg::PC_W-1:0] pc;
   logic [mcx_pkg::INSTR_W-1:0] ir;
   logic [7:0] acc;
   mcx_pkg::mcx_flags_s flags;
   logic global_interrupt_enable;
   logic int_hold;
   logic timeout_flag;
   logic powerdown_flag;
   logic [7:0] table_high_pointer;
   logic [mcx_pkg::PRESC_W-1:0] shared_prescaler;
   logic [mcx_pkg::WDOG_W-1:0] watchdog_counter;
   mcx_pkg::mcx_ctrl_s ctrl;
   logic [7:0] fpage [mcx_pkg::FPAGE_LO:mcx_pkg::FPAGE_HI];
   logic [$clog2(STACK_DEPTH)-1:0] stack_ptr;
   logic [mcx_pkg::PC_W-1:0] stack_top;

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == 8'h00);
   endfunction

   // packed-decimal fix-up of a binary sum; returns {carry, value}
   function automatic logic [8:0] bcd_fix(input logic [7:0] v,
                                          input logic cy,
                                          input logic hc);
      logic [8:0] t;
      t = {1'b0, v};
      if (hc || t[3:0] > 4'h9) begin
         t = t + 9'h006;
      end
      if (cy || t[8] || t[7:4] > 4'h9) begin
         t = t + 9'h060;
      end
      bcd_fix = {t[8] | cy, t[7:0]};
   endfunction

   // ***************************************************************
   // instruction fields
   // ***************************************************************
   wire logic adv = ctrl.run & ~int_hold;
   wire logic [5:0] opc = ir[13:8];
   wire logic bit_skip_op = (ir[13:10] == mcx_pkg::BIT_SKIP_PREFIX);
   wire logic [2:0] bit_sel = ir[9:7];
   wire logic dest_reg = ir[7];
   wire logic [6:0] reg_addr = ir[6:0];
   wire logic [7:0] imm = ir[7:0];
   wire logic [3:0] fsel = ir[3:0];
   logic [7:0] rval;

   // read address leads by one cycle so data lines up with the opcode
   wire logic [6:0] rd_addr = adv ? PM_DATA[6:0] : reg_addr;

   // ***************************************************************
   // datapath
   // ***************************************************************
   // subtract as register plus inverted accumulator plus one
   wire logic [8:0] cmp_sum = {1'b0, rval} + {1'b0, ~acc} + 9'h001;
   wire logic [8:0] add_sum = {1'b0, rval} + {1'b0, acc};
   wire logic [4:0] add_nib = {1'b0, rval[3:0]} + {1'b0, acc[3:0]};
   wire logic [8:0] daa_res = bcd_fix(acc, flags.c, flags.dc);
   wire logic [7:0] inc_res = rval + 8'h01;
   wire logic [7:0] dec_res = rval - 8'h01;

   logic [7:0] res;
   logic to_acc;
   logic to_reg;
   logic z_upd;
   logic c_upd;
   logic c_new;
   logic dc_upd;
   logic skip;
   logic jump;
   logic [mcx_pkg::PC_W-1:0] jump_pc;
   logic push;
   logic gie_set;
   logic gie_clr;
   logic wd_clr;
   logic f_we;

   // decode one instruction; every effect is gated by adv further down
   always_comb begin
      res = 8'h00;
      to_acc = 1'b0;
      to_reg = 1'b0;
      z_upd = 1'b0;
      c_upd = 1'b0;
      c_new = flags.c;
      dc_upd = 1'b0;
      skip = 1'b0;
      jump = 1'b0;
      jump_pc = pc;
      push = 1'b0;
      gie_set = 1'b0;
      gie_clr = 1'b0;
      wd_clr = 1'b0;
      f_we = 1'b0;
      if (bit_skip_op) begin
         skip = rval[bit_sel]; // RQ1
      end else begin
         case (opc)
            mcx_pkg::OP_CLEAR_ACC: begin
               res = 8'h00; // RQ2
               to_acc = 1'b1;
               z_upd = 1'b1;
            end
            mcx_pkg::OP_CLEAR_REG: begin
               res = 8'h00; // RQ3
               to_reg = 1'b1;
               z_upd = 1'b1;
            end
            mcx_pkg::OP_COMPLEMENT: begin
               res = ~rval; // RQ4
               to_acc = ~dest_reg; // RQ5
               to_reg = dest_reg; // RQ5
               z_upd = 1'b1;
            end
            mcx_pkg::OP_COMPARE: begin
               res = cmp_sum[7:0]; // RQ7
               z_upd = 1'b1;
               c_upd = 1'b1;
               c_new = cmp_sum[8]; // RQ21
            end
            mcx_pkg::OP_ADD_REG: begin
               res = add_sum[7:0];
               to_acc = ~dest_reg;
               to_reg = dest_reg;
               z_upd = 1'b1;
               c_upd = 1'b1;
               c_new = add_sum[8]; // RQ21
               dc_upd = 1'b1;
            end
            mcx_pkg::OP_DEC_ADJUST: begin
               res = daa_res[7:0]; // RQ8
               to_acc = 1'b1;
               c_upd = 1'b1;
               c_new = daa_res[8];
            end
            mcx_pkg::OP_DEC_SKIP: begin
               res = dec_res; // RQ10
               to_acc = ~dest_reg;
               to_reg = dest_reg;
               skip = is_zero(dec_res); // RQ10
            end
            mcx_pkg::OP_DECREMENT: begin
               res = dec_res; // RQ11
               to_acc = ~dest_reg;
               to_reg = dest_reg;
               z_upd = 1'b1;
            end
            mcx_pkg::OP_IRQ_DISABLE: gie_clr = 1'b1; // RQ12
            mcx_pkg::OP_IRQ_ENABLE: gie_set = 1'b1; // RQ13
            mcx_pkg::OP_INCREMENT: begin
               res = inc_res; // RQ14
               to_acc = ~dest_reg;
               to_reg = dest_reg;
               z_upd = 1'b1;
            end
            mcx_pkg::OP_INC_SKIP: begin
               res = inc_res; // RQ15
               to_acc = ~dest_reg;
               to_reg = dest_reg;
               skip = is_zero(inc_res); // RQ15
            end
            mcx_pkg::OP_BRANCH_ACC: begin
               jump = 1'b1;
               jump_pc = {table_high_pointer[2:0], acc}; // RQ16
            end
            mcx_pkg::OP_SOFT_INT: begin
               jump = 1'b1;
               jump_pc = mcx_pkg::SOFT_INT_VECTOR; // RQ17
               push = 1'b1;
            end
            mcx_pkg::OP_OR_IMM: begin
               res = acc | imm; // RQ18
               to_acc = 1'b1;
               z_upd = 1'b1;
            end
            mcx_pkg::OP_OR_REG: begin
               res = acc | rval; // RQ19
               to_acc = ~dest_reg;
               to_reg = dest_reg;
               z_upd = 1'b1;
            end
            mcx_pkg::OP_FPAGE_STORE: begin
               // bytes outside 5..15 are not implemented: store dropped
               f_we = (fsel >= mcx_pkg::FPAGE_LO); // RQ20
            end
            mcx_pkg::OP_WDOG_CLEAR: wd_clr = 1'b1; // RQ6
            default: res = 8'h00;
         endcase
      end
   end

   // ***************************************************************
   // storage instances
   // ***************************************************************
   mcx_pkg::mcx_wport_s wport;
   assign wport.we = adv & to_reg; // RQ5
   assign wport.addr = reg_addr;
   assign wport.data = res;

   mcx_dreg_ram #(
      .AW(mcx_pkg::RADDR_W),
      .DW(mcx_pkg::DATA_W)
   ) u_dreg (
      .clk(CORE_CLK),
      .wport(wport),
      .rd_addr(rd_addr),
      .rd_data(rval)
   );

   // pc already points past the interrupt opcode, so it is the return
   mcx_ret_stack #(
      .DEPTH(STACK_DEPTH),
      .AW(mcx_pkg::PC_W)
   ) u_stack (
      .clk(CORE_CLK),
      .rst_n(RSTN),
      .push(adv & push), // RQ24
      .push_addr(pc), // RQ17
      .ptr(stack_ptr),
      .top(stack_top)
   );

   // ***************************************************************
   // fetch and sequencing
   // ***************************************************************
   // a skip or jump replaces the fetched word by a nop; the soft
   // interrupt also holds one extra cycle to make its third cycle
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pc <= '0;
         ir <= mcx_pkg::NOP_WORD;
         int_hold <= 1'b0;
      end else if (adv) begin
         pc <= jump ? jump_pc : pc + 11'h001; // RQ16
         ir <= (skip | jump) ? mcx_pkg::NOP_WORD : PM_DATA; // RQ1
         int_hold <= push; // RQ17
      end else if (ctrl.run) begin
         int_hold <= 1'b0;
      end
   end

   // accumulator and status flags
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         acc <= 8'h00;
         flags <= '0;
      end else if (adv) begin
         if (to_acc) acc <= res; // RQ5
         if (z_upd) flags.z <= is_zero(res); // RQ23
         if (c_upd) flags.c <= c_new; // RQ21
         if (dc_upd) flags.dc <= add_nib[4];
      end
   end

   // global interrupt enable
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         global_interrupt_enable <= 1'b0;
      end else if (adv && gie_clr) begin
         global_interrupt_enable <= 1'b0; // RQ12
      end else if (adv && gie_set) begin
         global_interrupt_enable <= 1'b1; // RQ13
      end
   end

   // f-page special bytes, written only by the store instruction
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = mcx_pkg::FPAGE_LO; i <= mcx_pkg::FPAGE_HI; i++) begin
            fpage[i] <= 8'h00;
         end
      end else if (adv && f_we) begin
         fpage[fsel] <= acc; // RQ20
      end
   end

   // ***************************************************************
   // watchdog
   // ***************************************************************
   wire logic wd_clr_x = adv & wd_clr;
   wire logic presc_tick = &shared_prescaler;
   wire logic wd_tick = ctrl.wdog_en &
                        (ctrl.presc_to_wdog ? presc_tick : 1'b1);
   wire logic wd_ovf = wd_tick & (&watchdog_counter) & ~wd_clr_x;

   // prescaler only clears with the watchdog when it is assigned to it
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         shared_prescaler <= '0;
         watchdog_counter <= '0;
      end else begin
         if (wd_clr_x && ctrl.presc_to_wdog) shared_prescaler <= '0; // RQ6
         else shared_prescaler <= shared_prescaler + 1'b1;
         if (wd_clr_x) watchdog_counter <= '0; // RQ6
         else if (wd_tick) watchdog_counter <= watchdog_counter + 1'b1;
      end
   end

   // a timeout in the same cycle as a clear cannot happen: wd_ovf is
   // masked by the clear, so the clear wins and the flag is set
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         timeout_flag <= 1'b1; // RQ22
         powerdown_flag <= 1'b1;
         WDOG_TIMEOUT <= 1'b0;
      end else begin
         WDOG_TIMEOUT <= wd_ovf;
         if (wd_ovf) timeout_flag <= 1'b0; // RQ22
         else if (wd_clr_x) timeout_flag <= 1'b1; // RQ6
         if (wd_clr_x) powerdown_flag <= 1'b1; // RQ6
      end
   end

   // ***************************************************************
   // apb slave
   // ***************************************************************
   wire logic apb_setup = PSEL & ~PENABLE;
   wire logic apb_access = PSEL & PENABLE;
   wire logic [3:0] fidx = PADDR[5:2];
   wire logic fpage_hit = (PADDR[11:6] == mcx_pkg::REG_FPAGE_BASE[11:6]) &&
                          (PADDR[1:0] == 2'b00) &&
                          (fidx >= mcx_pkg::FPAGE_LO);
   logic [31:0] rd_val;
   logic hit;

   // address decode; unmapped words read zero and raise the error
   always_comb begin
      rd_val = 32'h0000_0000;
      hit = 1'b1;
      if (PADDR == mcx_pkg::REG_CTRL) begin
         rd_val = {29'h0, ctrl};
      end else if (PADDR == mcx_pkg::REG_STATUS) begin
         rd_val = {26'h0, powerdown_flag, timeout_flag, global_interrupt_enable, flags};
      end else if (PADDR == mcx_pkg::REG_ACC) begin
         rd_val = {24'h0, acc};
      end else if (PADDR == mcx_pkg::REG_PC) begin
         rd_val = {21'h0, pc};
      end else if (PADDR == mcx_pkg::REG_TBL_HIGH) begin
         rd_val = {24'h0, table_high_pointer};
      end else if (PADDR == mcx_pkg::REG_WDOG) begin
         rd_val = {16'h0, shared_prescaler, watchdog_counter};
      end else if (PADDR == mcx_pkg::REG_STACK) begin
         rd_val = {13'h0, stack_ptr, 5'h00, stack_top};
      end else if (fpage_hit) begin
         rd_val = {24'h0, fpage[fidx]};
      end else begin
         hit = 1'b0;
      end
   end

   // zero wait states: the access phase always completes at once
   assign PREADY = 1'b1;
   assign PSLVERR = apb_access & ~hit;

   // read data captured in the setup phase so it stands in access
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         PRDATA <= 32'h0000_0000;
      end else if (apb_setup && !PWRITE) begin
         PRDATA <= rd_val;
      end
   end

   // writable words: control and table high pointer
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ctrl <= mcx_pkg::CTRL_RESET;
         table_high_pointer <= mcx_pkg::TBL_HIGH_RESET;
      end else if (apb_access && PWRITE) begin
         if (PADDR == mcx_pkg::REG_CTRL) ctrl <= PWDATA[2:0];
         if (PADDR == mcx_pkg::REG_TBL_HIGH) begin
            table_high_pointer <= PWDATA[7:0];
         end
      end
   end

   assign PM_ADDR = pc;
   assign GLOBAL_IRQ_EN = global_interrupt_enable;

endmodule

// ==== sim/mcx_pmem.sv ====
// program memory model: 2K words of 14 bits
// assumes: bench loads words while the core sits in reset
module mcx_pmem (
   input wire logic [10:0] addr, // fetch address
   output logic [13:0] data      // instruction word
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [13:0] rom [0:2047];
   // asynchronous read, the core samples it at the same edge
   assign data = rom[addr];
endmodule

// ==== sim/mcx_core_assertions.sv ====
// checker for the core's apb port and status outputs
// assumes: bound to mcx_core, one clock domain
module mcx_core_assertions #(
   parameter int STACK_DEPTH = 8
) (
   input wire logic CORE_CLK,         // clk
   input wire logic RSTN,             // rst
   input wire logic [10:0] PM_ADDR,   // fetch
   input wire logic [13:0] PM_DATA,   // word
   input wire logic GLOBAL_IRQ_EN,    // gie
   input wire logic WDOG_TIMEOUT,     // pulse
   input wire logic PSEL,             // apb
   input wire logic PENABLE,          // apb
   input wire logic PWRITE,           // apb
   input wire logic [11:0] PADDR,     // apb
   input wire logic [31:0] PWDATA,    // apb
   input wire logic [31:0] PRDATA,    // apb
   input wire logic PREADY,           // apb
   input wire logic PSLVERR           // apb
);
   // ************************************
   // apb and status relations
   // ************************************
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RSTN);
   wire acc_ph = PSEL && PENABLE;
   // a read setup aimed at a hole in the map
   sequence s_bad_rd;
      PSEL && !PENABLE && !PWRITE && PADDR == 12'h020;
   endsequence
   a_ready_high: assert property (PREADY)
      else $error("ready low");
   a_err_access: assert property (PSLVERR |-> acc_ph)
      else $error("error outside access");
   a_err_hole: assert property (acc_ph && PADDR == 12'h020 |-> PSLVERR)
      else $error("no error on hole");
   a_err_mapped: assert property (acc_ph && PADDR == 12'h008 |-> !PSLVERR)
      else $error("error on mapped word");
   a_rdata_hold: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
      else $error("read data moved");
   a_hole_zero: assert property (s_bad_rd |=> PRDATA == 32'h0)
      else $error("hole read not zero");
   a_gie_step: assert property ($changed(GLOBAL_IRQ_EN) |->
      $changed(PM_ADDR)) else $error("gie moved without execution");
   a_tmo_pulse: assert property (WDOG_TIMEOUT |=> !WDOG_TIMEOUT)
      else $error("timeout pulse too long");
endmodule
bind mcx_core mcx_core_assertions #(.STACK_DEPTH(STACK_DEPTH)) chk_i (
   .CORE_CLK(CORE_CLK), .RSTN(RSTN), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA),
   .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .WDOG_TIMEOUT(WDOG_TIMEOUT), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

// ==== sim/mcx_core_bench.sv ====
// bench: runs a short program per test, reads results over apb
// assumes: core, program memory model and checker compiled first
module mcx_core_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] padr = 12'h000;
   logic [31:0] pwd = 32'h0, rd;
   logic [10:0] pma;
   logic [13:0] pmd;
   logic [7:0] a, r5;
   logic [2:0] k;
   logic [31:0] prd;
   logic rdy, err, g, z, c;
   int miscompares = 0, n_tests = 0, seed = 32'h05a7, n;
   always #5 clk = ~clk;
   mcx_pmem mcx_pmem_i (.addr(pma), .data(pmd));
   mcx_core mcx_core_i (.CORE_CLK(clk), .RSTN(rstn), .PM_ADDR(pma),
      .PM_DATA(pmd), .GLOBAL_IRQ_EN(), .WDOG_TIMEOUT(), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
      .PRDATA(prd), .PREADY(rdy), .PSLVERR(err));
   // ************************************
   // tasks
   // ************************************
   function automatic logic [13:0] op(logic [5:0] o, logic [7:0] f);
      return {o, f};
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // setup, then access held until ready is seen high
   task automatic apb(logic w, logic [11:0] ad, logic [31:0] wd);
      int t;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      padr <= ad;
      pwd <= wd;
      @(posedge clk);
      pen <= 1'b1;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (rdy !== 1'b1 && t < 20);
      if (rdy !== 1'b1) begin
         miscompares++;
         final_report();
      end
      rd = prd;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // ************************************
   // main sequence: first test is the a=ff corner
   // ************************************
   initial begin
      for (int it = 0; it < 4; it++) begin
         a = (it == 0) ? 8'hff : 8'($random(seed));
         k = 3'($random(seed));
         rstn <= 1'b0;
         for (int i = 0; i < 2048; i++)
            mcx_pmem_i.rom[i] = mcx_pkg::NOP_WORD;
         mcx_pmem_i.rom[0] = op(mcx_pkg::OP_BRANCH_ACC, 8'h00);
         mcx_pmem_i.rom[11'h200] = op(mcx_pkg::OP_CLEAR_ACC, 8'h00);
         mcx_pmem_i.rom[11'h201] = op(mcx_pkg::OP_OR_IMM, a);
         mcx_pmem_i.rom[11'h202] = op(mcx_pkg::OP_CLEAR_REG, 8'h05);
         mcx_pmem_i.rom[11'h203] = op(mcx_pkg::OP_OR_REG, 8'h85);
         mcx_pmem_i.rom[11'h204] = op(mcx_pkg::OP_COMPLEMENT, 8'h05);
         mcx_pmem_i.rom[11'h205] = op(mcx_pkg::OP_COMPARE, 8'h05);
         mcx_pmem_i.rom[11'h206] = op(mcx_pkg::OP_INC_SKIP, 8'h85);
         mcx_pmem_i.rom[11'h207] = op(mcx_pkg::OP_IRQ_ENABLE, 8'h00);
         mcx_pmem_i.rom[11'h208] = op(mcx_pkg::OP_DECREMENT, 8'h05);
         mcx_pmem_i.rom[11'h209] = op(mcx_pkg::OP_FPAGE_STORE, 8'h07);
         mcx_pmem_i.rom[11'h20a] = {mcx_pkg::BIT_SKIP_PREFIX, k, 7'h05};
         mcx_pmem_i.rom[11'h20b] = op(mcx_pkg::OP_IRQ_DISABLE, 8'h00);
         mcx_pmem_i.rom[11'h20c] = op(mcx_pkg::OP_SOFT_INT, 8'h00);
         repeat (16) @(posedge clk);
         rstn <= 1'b1;
         apb(1'b1, mcx_pkg::REG_TBL_HIGH, 32'h2);
         apb(1'b1, mcx_pkg::REG_CTRL, 32'h1);
         n = 0;
         do begin
            apb(1'b0, mcx_pkg::REG_STACK, 32'h0);
            n++;
         end while (rd[18:16] === 3'h0 && n < 40);
         if (rd[18:16] === 3'h0) begin
            miscompares++;
            final_report();
         end
         apb(1'b1, mcx_pkg::REG_CTRL, 32'h0);
         // expected state from the program's arithmetic
         r5 = a + 8'h01;
         g = r5[k] & ~&a; // enable ran and disable skipped
         z = (a == 8'h00);
         c = a >= ~a;
         apb(1'b0, mcx_pkg::REG_ACC, 32'h0);
         chk(rd, {24'h0, a});
         apb(1'b0, mcx_pkg::REG_STATUS, 32'h0);
         chk(rd, {28'h3, g, 1'b0, c, z});
         apb(1'b0, mcx_pkg::REG_FPAGE_BASE + 12'h01c, 32'h0);
         chk(rd, {24'h0, a});
         apb(1'b0, mcx_pkg::REG_STACK, 32'h0);
         chk(rd, {13'h0, 3'h1, 5'h0, 11'h20d});
         apb(1'b0, 12'h020, 32'h0);
         chk(rd, 32'h0);
         $display("test %0d done", it);
      end
      final_report();
   end
endmodule
